//--- hw/rmd_regs.sv
/*
 rmd_regs: control pin power-good masks, termination discharge select and
 auxiliary rail control, reached over AXI4-Lite.
 assumes all pins are synchronous to core_clk and the factory defaults are
 stable at the otp_* ports when reset is released.
*/
`timescale 1ns/10ps
module rmd_regs
    import rmd_pkg::*;
#(
    parameter int CYCLES_PER_MS = RMD_CYCLES_PER_MS
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // axi4-lite write
    input wire logic [RMD_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [RMD_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // factory configuration
    input wire logic [7:0] otp_pg_mask,
    input wire logic [7:0] otp_term_disch,
    input wire logic [7:0] otp_aux_ctrl,
    input wire logic [1:0] otp_off_sel,
    input wire logic otp_target_switch_two,
    input wire logic aux_in_sequence,
    input wire logic switches_merged,
    // power-good trees
    input wire logic [3:0] rail_pg_tree,
    input wire logic control_input_three,
    input wire logic control_input_six,
    output logic pg_output_one,
    output logic pg_output_two,
    output logic pg_output_three,
    output logic pg_output_four,
    // rail controls
    input wire logic emergency_shutdown,
    output logic termination_discharge_on,
    output logic [1:0] aux_discharge_sel,
    output logic [3:0] aux_voltage_code,
    output logic aux_regulator_on,
    output logic load_switch_two_on
);
    logic [7:0] ctl_pin_pg_mask_reg;
    logic [7:0] termination_discharge_ctrl_reg;
    logic [7:0] aux_rail_ctrl_reg;
    logic otp_loaded_reg;
    logic [3:0] pg_out_reg;
    logic aux_reg_on_reg, sw2_on_reg;
    logic [3:0] pg_calc;
    logic wr_en, wr_hit, rd_hit, off_busy;
    logic [RMD_IDX_W-1:0] wr_idx, rd_idx;
    logic [7:0] wr_data, rd_data, status_word;

    rmd_axil_slave u_bus (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_idx(wr_idx),
        .wr_data(wr_data),
        .wr_hit(wr_hit),
        .rd_idx(rd_idx),
        .rd_data(rd_data),
        .rd_hit(rd_hit)
    );

    // address decode
    wire wr_mask = wr_en && (wr_idx == RMD_IDX_PG_MASK);
    wire wr_term = wr_en && (wr_idx == RMD_IDX_TERM_DISCH);
    wire wr_aux = wr_en && (wr_idx == RMD_IDX_AUX_CTRL);
    // the status word is read-only; a write to it is answered and dropped
    assign wr_hit = (wr_idx >= RMD_IDX_PG_MASK) && (wr_idx <= RMD_IDX_STATUS);
    assign rd_hit = (rd_idx >= RMD_IDX_PG_MASK) && (rd_idx <= RMD_IDX_STATUS);
    assign status_word = {otp_loaded_reg, off_busy, sw2_on_reg, aux_reg_on_reg, pg_out_reg[3:0]};
    assign rd_data = (rd_idx == RMD_IDX_PG_MASK) ? ctl_pin_pg_mask_reg :
                     (rd_idx == RMD_IDX_TERM_DISCH) ? termination_discharge_ctrl_reg :
                     (rd_idx == RMD_IDX_AUX_CTRL) ? aux_rail_ctrl_reg :
                     (rd_idx == RMD_IDX_STATUS) ? status_word : 8'h00;

    // factory defaults are taken on the first edge after reset release,
    // since an async reset may only load constants
    wire otp_load = !otp_loaded_reg;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            otp_loaded_reg <= 1'b0;
            ctl_pin_pg_mask_reg <= RMD_REG_RST;
            termination_discharge_ctrl_reg <= RMD_REG_RST;
            aux_rail_ctrl_reg <= RMD_REG_RST;
        end
        else if (otp_load)
        begin
            otp_loaded_reg <= 1'b1;
            ctl_pin_pg_mask_reg <= otp_pg_mask;
            termination_discharge_ctrl_reg <= otp_term_disch;
            aux_rail_ctrl_reg <= otp_aux_ctrl;
        end
        else
        begin
            if (wr_mask)
                ctl_pin_pg_mask_reg <= wr_data;
            // reserved bits are stored as written
            if (wr_term)
                termination_discharge_ctrl_reg <= wr_data;
            if (wr_aux)
                aux_rail_ctrl_reg <= wr_data;
        end
    end

    // a mask bit of one forces its pin term true
    genvar g;
    for (g = 0; g < 4; g++)
    begin : g_tree
        assign pg_calc[g] = rail_pg_tree[g]
            & (control_input_three | ctl_pin_pg_mask_reg[RMD_IN3_BIT[g]])
            & (control_input_six | ctl_pin_pg_mask_reg[RMD_IN6_BIT[g]]);
    end

    // emergency shutdown and rail enables
    wire sdwn_bypass = aux_rail_ctrl_reg[RMD_AUX_SDWN_BIT];
    wire aux_en = aux_rail_ctrl_reg[RMD_AUX_EN_BIT];
    wire off_start = emergency_shutdown && !sdwn_bypass && otp_loaded_reg;
    wire sdwn_on_sw2 = aux_in_sequence && !switches_merged;
    // setting the bypass bit releases a running off period at once
    wire force_off = off_busy && !sdwn_bypass;
    wire force_sw2 = force_off && (sdwn_on_sw2 || otp_target_switch_two);
    wire force_reg = force_off && !sdwn_on_sw2 && !otp_target_switch_two;
    wire aux_reg_on_next = aux_en && !otp_target_switch_two && !force_reg;
    wire sw2_on_next = aux_en && otp_target_switch_two && !force_sw2;

    rmd_off_timer #(
        .CYCLES_PER_MS(CYCLES_PER_MS)
    ) u_off_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(off_start),
        .off_sel(otp_off_sel),
        .busy(off_busy)
    );

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pg_out_reg <= 4'h0;
            aux_reg_on_reg <= 1'b0;
            sw2_on_reg <= 1'b0;
        end
        else
        begin
            pg_out_reg <= pg_calc;
            aux_reg_on_reg <= aux_reg_on_next;
            sw2_on_reg <= sw2_on_next;
        end
    end

    assign pg_output_one = pg_out_reg[0];
    assign pg_output_two = pg_out_reg[1];
    assign pg_output_three = pg_out_reg[2];
    assign pg_output_four = pg_out_reg[3];
    assign termination_discharge_on = termination_discharge_ctrl_reg[RMD_TERM_DISCH_BIT];
    assign aux_discharge_sel = aux_rail_ctrl_reg[RMD_AUX_DISCH_HI:RMD_AUX_DISCH_LO];
    assign aux_voltage_code = aux_rail_ctrl_reg[RMD_AUX_VID_HI:RMD_AUX_VID_LO];
    assign aux_regulator_on = aux_reg_on_reg;
    assign load_switch_two_on = sw2_on_reg;

    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    logic pg_four_calc;
    assign pg_four_calc = pg_calc[3];

    a_in3_unmasked_one: assert property (
        otp_loaded_reg && !control_input_three && !ctl_pin_pg_mask_reg[7] |=> !pg_output_one)
        else $error("pin three low but output one still good");

    a_in3_masked_three: assert property (
        otp_loaded_reg && rail_pg_tree[2] && control_input_six && ctl_pin_pg_mask_reg[1]
        |=> pg_output_three)
        else $error("masked pin three pulled output three low");

    a_in6_unmasked_two: assert property (
        otp_loaded_reg && !control_input_six && !ctl_pin_pg_mask_reg[2] |=> !pg_output_two)
        else $error("pin six low but output two still good");

    a_pg_tree_and: assert property (
        otp_loaded_reg |=> pg_output_four == $past(pg_four_calc))
        else $error("output four does not follow its tree");

    a_pg_tree_low: assert property (
        !rail_pg_tree[1] |=> !pg_output_two)
        else $error("output two good with its rail tree low");

    a_term_disch_write: assert property (
        otp_loaded_reg && wr_term |=> termination_discharge_on == $past(wr_data[4]))
        else $error("termination discharge did not take the written bit");

    a_aux_disch_write: assert property (
        otp_loaded_reg && wr_aux |=> aux_discharge_sel == $past(wr_data[7:6]))
        else $error("aux discharge select did not take the written field");

    a_vid_write: assert property (
        otp_loaded_reg && wr_aux |=> aux_voltage_code == $past(wr_data[4:1]))
        else $error("voltage code did not take the written field");

    a_sdwn_forces_off: assert property (
        off_start && !sdwn_on_sw2 ##1 !sdwn_bypass |=> !aux_regulator_on)
        else $error("aux regulator stayed on in emergency shutdown");

    a_sdwn_bypass_on: assert property (
        sdwn_bypass && aux_en && !otp_target_switch_two |=> aux_regulator_on)
        else $error("bypass set and enabled but aux regulator off");

    a_sdwn_on_sw2: assert property (
        off_start && sdwn_on_sw2 ##1 !sdwn_bypass |=> !load_switch_two_on)
        else $error("switch two stayed on in emergency shutdown");

    a_enable_off: assert property (
        !aux_en |=> !aux_regulator_on && !load_switch_two_on)
        else $error("rail on with enable bit clear");

    a_otp_default_load: assert property (
        otp_load |=> ctl_pin_pg_mask_reg == $past(otp_pg_mask) && aux_rail_ctrl_reg == $past(otp_aux_ctrl))
        else $error("factory defaults not loaded after reset");

    a_in3_unmasked_two: assert property (
        otp_loaded_reg && !control_input_three && !ctl_pin_pg_mask_reg[3] |=> !pg_output_two)
        else $error("pin three low but output two still good");

    a_in3_unmasked_three: assert property (
        otp_loaded_reg && !control_input_three && !ctl_pin_pg_mask_reg[1] |=> !pg_output_three)
        else $error("pin three low but output three still good");

    a_in3_unmasked_four: assert property (
        otp_loaded_reg && !control_input_three && !ctl_pin_pg_mask_reg[5] |=> !pg_output_four)
        else $error("pin three low but output four still good");

    a_in6_unmasked_one: assert property (
        otp_loaded_reg && !control_input_six && !ctl_pin_pg_mask_reg[6] |=> !pg_output_one)
        else $error("pin six low but output one still good");

    a_in6_unmasked_three: assert property (
        otp_loaded_reg && !control_input_six && !ctl_pin_pg_mask_reg[0] |=> !pg_output_three)
        else $error("pin six low but output three still good");

    a_in6_masked_four: assert property (
        otp_loaded_reg && rail_pg_tree[3] && control_input_three && ctl_pin_pg_mask_reg[4]
        |=> pg_output_four)
        else $error("masked pin six pulled output four low");

    a_term_disch_hold: assert property (
        otp_loaded_reg && !wr_term |=> $stable(termination_discharge_on))
        else $error("termination discharge changed without a write");

    a_vid_hold: assert property (
        otp_loaded_reg && !wr_aux |=> $stable(aux_voltage_code))
        else $error("voltage code changed without a write");

    a_enable_sw2_on: assert property (
        sdwn_bypass && aux_en && otp_target_switch_two |=> load_switch_two_on)
        else $error("bypass set and enabled but switch two off");

    a_sw2_target_reg_off: assert property (
        otp_target_switch_two |=> !aux_regulator_on)
        else $error("aux regulator on while enable drives switch two");

    c_mask_write: cover property (wr_mask ##1 s_axi_bvalid);
    c_sdwn_timed: cover property (off_start ##1 off_busy [*3] ##1 aux_regulator_on);
    c_sdwn_bypass: cover property (emergency_shutdown && sdwn_bypass && aux_regulator_on);
    c_status_read: cover property (s_axi_arvalid && s_axi_arready && rd_idx == RMD_IDX_STATUS);
endmodule : rmd_regs

//--- hw/rmd_pkg.sv
/*
 rmd_pkg: register indices, field positions, bus answers and timing for the
 rail mask and discharge control bank.
 assumes a 100 MHz core clock and AXI4-Lite access with 32-bit data words.
*/
package rmd_pkg;
    // byte address of a register is four times its index
    localparam int RMD_ADDR_W = 12;
    localparam int RMD_IDX_W = 10;
    localparam logic [9:0] RMD_IDX_PG_MASK = 10'h0AC;
    localparam logic [9:0] RMD_IDX_TERM_DISCH = 10'h0AD;
    localparam logic [9:0] RMD_IDX_AUX_CTRL = 10'h0AE;
    localparam logic [9:0] RMD_IDX_STATUS = 10'h0AF;
    // mask bit per output one, two, three, four
    localparam int RMD_IN3_BIT [4] = '{7, 3, 1, 5};
    localparam int RMD_IN6_BIT [4] = '{6, 2, 0, 4};
    localparam int RMD_TERM_DISCH_BIT = 4;
    localparam int RMD_AUX_DISCH_HI = 7;
    localparam int RMD_AUX_DISCH_LO = 6;
    localparam int RMD_AUX_SDWN_BIT = 5;
    localparam int RMD_AUX_VID_HI = 4;
    localparam int RMD_AUX_VID_LO = 1;
    localparam int RMD_AUX_EN_BIT = 0;
    localparam logic [7:0] RMD_REG_RST = 8'h00;
    localparam logic [1:0] RMD_RESP_OKAY = 2'h0;
    localparam logic [1:0] RMD_RESP_SLVERR = 2'h2;
    localparam int RMD_CLK_PERIOD_NS = 10;
    localparam int RMD_NS_PER_MS = 1000000;
    localparam int RMD_CYCLES_PER_MS = RMD_NS_PER_MS / RMD_CLK_PERIOD_NS;
    // emergency off time in ms: 1, 5, 10, 100
    localparam logic [6:0] RMD_OFF_MS [4] = '{7'h01, 7'h05, 7'h0A, 7'h64};
endpackage : rmd_pkg

//--- hw/rmd_off_timer.sv
/*
 rmd_off_timer: counts the emergency off time in whole milliseconds.
 assumes start is a one-cycle pulse; a new start restarts the count.
*/
`timescale 1ns/10ps
module rmd_off_timer
    import rmd_pkg::*;
#(
    parameter int CYCLES_PER_MS = RMD_CYCLES_PER_MS
)(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // control
    input wire logic start,
    input wire logic [1:0] off_sel,
    output logic busy
);
    localparam int DIV_W = $clog2(CYCLES_PER_MS + 1);
    logic [DIV_W-1:0] div_reg;
    logic [6:0] ms_left_reg;
    logic busy_reg;
    wire ms_tick = busy_reg && (div_reg == DIV_W'(CYCLES_PER_MS - 1));
    wire last_ms = (ms_left_reg == 7'h01);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_reg <= '0;
            ms_left_reg <= 7'h00;
            busy_reg <= 1'b0;
        end
        else if (start)
        begin
            div_reg <= '0;
            ms_left_reg <= RMD_OFF_MS[off_sel];
            busy_reg <= 1'b1;
        end
        else if (ms_tick)
        begin
            div_reg <= '0;
            ms_left_reg <= ms_left_reg - 7'h01;
            busy_reg <= !last_ms;
        end
        else if (busy_reg)
            div_reg <= div_reg + DIV_W'(1);
    end

    assign busy = busy_reg;
endmodule : rmd_off_timer

//--- hw/rmd_axil_slave.sv
/*
 rmd_axil_slave: AXI4-Lite slave front end for an 8-bit register bank.
 assumes the bank answers rd_data and the hit flags combinationally.
*/
`timescale 1ns/10ps
module rmd_axil_slave
    import rmd_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // write channels
    input wire logic [RMD_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read channels
    input wire logic [RMD_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // bank side
    output logic wr_en,
    output logic [RMD_IDX_W-1:0] wr_idx,
    output logic [7:0] wr_data,
    input wire logic wr_hit,
    output logic [RMD_IDX_W-1:0] rd_idx,
    input wire logic [7:0] rd_data,
    input wire logic rd_hit
);
    logic aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
    logic [RMD_IDX_W-1:0] awidx_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [7:0] rdata_reg;

    // address and data are taken in either order, one write in flight
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign s_axi_arready = !rvalid_reg;
    assign wr_idx = awidx_reg;
    assign wr_data = wdata_reg;
    // only the low byte lane carries register data
    assign wr_en = wr_fire && wstrb0_reg;
    assign rd_idx = s_axi_araddr[RMD_ADDR_W-1:2];

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            awidx_reg <= '0;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
            bresp_reg <= RMD_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                awidx_reg <= s_axi_awaddr[RMD_ADDR_W-1:2];
            if (w_take)
                wdata_reg <= s_axi_wdata[7:0];
            if (w_take)
                wstrb0_reg <= s_axi_wstrb[0];
            aw_hold_reg <= wr_fire ? 1'b0 : (aw_hold_reg || aw_take);
            w_hold_reg <= wr_fire ? 1'b0 : (w_hold_reg || w_take);
            if (wr_fire)
                bresp_reg <= wr_hit ? RMD_RESP_OKAY : RMD_RESP_SLVERR;
            bvalid_reg <= wr_fire || (bvalid_reg && !s_axi_bready);
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 8'h00;
            rresp_reg <= RMD_RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_hit ? rd_data : 8'h00;
            rresp_reg <= rd_hit ? RMD_RESP_OKAY : RMD_RESP_SLVERR;
        end
        else if (s_axi_rready)
            rvalid_reg <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = {24'h000000, rdata_reg};
endmodule : rmd_axil_slave

//--- dv/tb.sv
/*
 tb: self-checking bench for rmd_regs, random register traffic over AXI4-Lite.
 assumes rmd_pkg and a 100 MHz core clock; the ms count is shortened to 2 cycles.
*/
`timescale 1ns/10ps
module tb
    import rmd_pkg::*;
;
    localparam int CPM = 2;
    localparam int W = 220;
    localparam int MS [4] = '{1, 5, 10, 100};
    logic core_clk, rst_n;
    logic [RMD_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, rail_pg_tree, aux_voltage_code;
    logic [1:0] s_axi_bresp, s_axi_rresp, otp_off_sel, aux_discharge_sel;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] otp_pg_mask, otp_term_disch, otp_aux_ctrl;
    logic otp_target_switch_two, aux_in_sequence, switches_merged, control_input_three, control_input_six;
    logic pg_output_one, pg_output_two, pg_output_three, pg_output_four;
    logic emergency_shutdown, termination_discharge_on, aux_regulator_on, load_switch_two_on;
    int mismatches, n_checks;

    rmd_regs #(.CYCLES_PER_MS(CPM)) u_rmd_regs (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .otp_pg_mask, .otp_term_disch, .otp_aux_ctrl, .otp_off_sel, .otp_target_switch_two, .aux_in_sequence,
        .switches_merged, .rail_pg_tree, .control_input_three, .control_input_six, .pg_output_one,
        .pg_output_two, .pg_output_three, .pg_output_four, .emergency_shutdown, .termination_discharge_on,
        .aux_discharge_sel, .aux_voltage_code, .aux_regulator_on, .load_switch_two_on);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    // each half is released on its own handshake; bready waits from the start
    task automatic wr(input logic [9:0] idx, input logic [7:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= {24'($urandom()), d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever
        begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && s_axi_bready)
            begin
                r = s_axi_bresp;
                s_axi_bready <= 1'h0;
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever
        begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && s_axi_rready)
            begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'h0;
                break;
            end
        end
    endtask : rd

    function automatic logic [3:0] pg_exp(input logic [7:0] m, input logic [3:0] t, input logic p3, p6);
        for (int i = 0; i < 4; i++)
            pg_exp[i] = t[i] & (p3 | m[RMD_IN3_BIT[i]]) & (p6 | m[RMD_IN6_BIT[i]]);
    endfunction : pg_exp

    // c = {off_sel, bypass, enable to switch two, in sequence, merged}; zero-count over the window
    function automatic int exp_z(input logic [5:0] c, input logic sw);
        int t;
        logic ft;
        t = MS[c[5:4]] * CPM;
        ft = c[2] | (c[1] & !c[0]);
        if (c[2] != sw)
            return W;
        return (!c[3] && (sw || !ft)) ? t : 0;
    endfunction : exp_z

    initial
    begin
        core_clk = 1'h0;
        forever #5 core_clk = ~core_clk;
    end

    // the whole run needs about 2350 cycles
    initial
    begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        report_and_stop();
    end

    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] otp [3];
        logic [7:0] v, m;
        logic [5:0] em [8] = '{6'h00, 6'h10, 6'h20, 6'h30, 6'h08, 6'h02, 6'h14, 6'h03};
        int zr, zs;
        d = $urandom(32'h6BDD);
        foreach (otp[i]) otp[i] = 8'($urandom());
        {otp_pg_mask, otp_term_disch, otp_aux_ctrl} = {otp[0], otp[1], otp[2]};
        {rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {24'h0, 32'h0, 4'hF};
        {otp_off_sel, otp_target_switch_two, aux_in_sequence, switches_merged} = 5'h00;
        {rail_pg_tree, control_input_three, control_input_six, emergency_shutdown} = 7'h00;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        for (int i = 0; i < 3; i++)
        begin
            rd(10'(RMD_IDX_PG_MASK + i), d, r);
            check(d, 32'(otp[i]));
        end
        // every field and the reserved bits read back as written
        for (int k = 0; k < 24; k++)
        begin
            v = 8'($urandom());
            wr(10'(RMD_IDX_PG_MASK + k % 3), v, r);
            check(32'(r), 32'(RMD_RESP_OKAY));
            rd(10'(RMD_IDX_PG_MASK + k % 3), d, r);
            check(d, 32'(v));
        end
        s_axi_wstrb <= 4'h0;
        wr(RMD_IDX_AUX_CTRL, ~v, r);
        s_axi_wstrb <= 4'hF;
        rd(RMD_IDX_AUX_CTRL, d, r);
        check(d, 32'(v));
        wr(RMD_IDX_STATUS, 8'hFF, r);
        check(32'(r), 32'(RMD_RESP_OKAY));
        rd(RMD_IDX_STATUS, d, r);
        check(d, 32'({1'h1, 2'h0, v[0], 4'h0}));
        wr(10'h0B0, 8'h5A, r);
        check(32'(r), 32'(RMD_RESP_SLVERR));
        rd(10'h0B0, d, r);
        check(d, 32'h0);
        check(32'(r), 32'(RMD_RESP_SLVERR));
        // masks against pins and trees, all-include and all-exclude first
        for (int k = 0; k < 40; k++)
        begin
            m = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($urandom());
            wr(RMD_IDX_PG_MASK, m, r);
            rail_pg_tree <= (k < 2) ? 4'hF : 4'($urandom());
            control_input_three <= (k < 2) ? 1'h0 : 1'($urandom());
            control_input_six <= (k < 2) ? 1'h0 : 1'($urandom());
            repeat (2) @(posedge core_clk);
            #1;
            check(32'({pg_output_four, pg_output_three, pg_output_two, pg_output_one}),
                32'(pg_exp(m, rail_pg_tree, control_input_three, control_input_six)));
        end
        for (int k = 0; k < 8; k++)
        begin
            v = {2'(k), 1'h1, 4'($urandom()), 1'($urandom())};
            wr(RMD_IDX_AUX_CTRL, v, r);
            m = 8'($urandom());
            wr(RMD_IDX_TERM_DISCH, m, r);
            @(posedge core_clk);
            #1;
            check(32'(aux_discharge_sel), 32'(v[7:6]));
            check(32'(aux_voltage_code), 32'(v[4:1]));
            check(32'({aux_regulator_on, load_switch_two_on}), 32'({v[0], 1'h0}));
            check(32'(termination_discharge_on), 32'(m[4]));
        end
        foreach (em[i])
        begin
            otp_off_sel <= em[i][5:4];
            {otp_target_switch_two, aux_in_sequence, switches_merged} <= em[i][2:0];
            wr(RMD_IDX_AUX_CTRL, {2'h0, em[i][3], 4'h5, 1'h1}, r);
            repeat (3) @(posedge core_clk);
            emergency_shutdown <= 1'h1;
            @(posedge core_clk);
            emergency_shutdown <= 1'h0;
            zr = 0;
            zs = 0;
            repeat (W)
            begin
                @(posedge core_clk);
                #1;
                zr += int'(!aux_regulator_on);
                zs += int'(!load_switch_two_on);
            end
            check(32'(zr), 32'(exp_z(em[i], 1'h0)));
            check(32'(zs), 32'(exp_z(em[i], 1'h1)));
        end
        report_and_stop();
    end
endmodule : tb
